// file: api_frame_map.svh
// Frame constants shared by both ends of the serial API link
`ifndef API_FRAME_MAP_SVH
`define API_FRAME_MAP_SVH
`define START_DELIM 8'h7e
`define ESC_BYTE 8'h7d
`define ESC_XOR 8'h20
`define XON_BYTE 8'h11
`define XOFF_BYTE 8'h13
`define CKSUM_GOOD 8'hff
`define LEN_HI_ZERO 8'h00
`define TYPE_LOCAL_REQ 8'h08
`define TYPE_LOCAL_RSP 8'h88
`define TYPE_TX_STATUS 8'h8b
`define TYPE_RX_PLAIN 8'h90
`define TYPE_RX_EXPLICIT 8'h91
`define TYPE_REMOTE_RSP 8'h97
`define FID_NONE 8'h00
`define BODY_TYPE 16'h0000
`define BODY_ID 16'h0001
`define BODY_CMD_HI 16'h0002
`define BODY_CMD_LO 16'h0003
`define BODY_PARAM 16'h0004
`define BODY_VALUE 16'h0005
`define BODY_BITS 72
`define ST_OK 8'h00
`define ST_BAD_CMD 8'h02
`define ST_BAD_PARAM 8'h03
`define CMD_RX_FMT 16'h414f
`define CMD_ESC_MODE 16'h4150
`define ESC_MODE_PLAIN 2'h1
`define ESC_MODE_ESCAPED 2'h2
`define RX_FMT_RST 1'b0
`define RSP_LEN_QUERY 8'h09
`define RSP_LEN_SET 8'h05
`define EV_LEN 8'h03
`define REQ_LEN_QUERY 8'h04
`define REQ_LEN_SET 8'h08
`define TX_HDR 4'h3
`define IDX_DELIM 4'h0
`define IDX_LEN_HI 4'h1
`define IDX_LEN_LO 4'h2
`endif

// file: api_frame_pkg.sv
// Types and the escape helper function of the serial API framing
package api_frame_pkg;
`include "api_frame_map.svh"
   typedef enum logic [1:0] {EV_TX_STATUS, EV_RX_DATA, EV_REMOTE_RSP} ev_kind_t;
   typedef enum logic [2:0] {RX_HUNT, RX_LEN_HI, RX_LEN_LO, RX_BODY, RX_CHK}
      rx_state_t;

   function automatic logic needs_escape(input logic [7:0] b);
      return b == `START_DELIM || b == `ESC_BYTE || b == `XON_BYTE ||
         b == `XOFF_BYTE;
   endfunction
endpackage

// file: api_link_if.sv
// Byte stream link between host and device, one stream each way
`timescale 1ns/1ps
interface api_link_if;
   logic [7:0] h2d_data;
   logic h2d_valid;
   logic h2d_ready;
   logic [7:0] d2h_data;
   logic d2h_valid;
   logic d2h_ready;

   modport device (
      input h2d_data, h2d_valid, d2h_ready,
      output h2d_ready, d2h_data, d2h_valid
   );
   modport host (
      input h2d_ready, d2h_data, d2h_valid,
      output h2d_data, h2d_valid, d2h_ready
   );
endinterface

// file: api_frame_device.sv
// Device end: FIFO, frame encoder, frame decoder and command handling
`timescale 1ns/1ps
`include "api_frame_map.svh"
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic [AW:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready = count != (AW + 1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data = mem[rptr];

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wptr] <= in_data;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wptr <= next_ptr(wptr);
         if (pop)
            rptr <= next_ptr(rptr);
         count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule // byte_fifo

module frame_encoder
   import api_frame_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Frame request, body left aligned
   input wire logic esc_on,
   input wire logic start,
   input wire logic [7:0] s_len,
   input wire logic [`BODY_BITS-1:0] s_body,
   output logic busy,
   // Byte stream out
   output logic [7:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [3:0] idx;
   logic [7:0] t_len;
   logic [7:0] t_sum;
   logic [`BODY_BITS-1:0] t_body;
   logic t_esc2;
   wire [3:0] last = t_len[3:0] + `TX_HDR;
   wire in_body = idx >= `TX_HDR && idx != last;
   wire [7:0] plain = (idx == `IDX_DELIM) ? `START_DELIM :
      (idx == `IDX_LEN_HI) ? `LEN_HI_ZERO :
      (idx == `IDX_LEN_LO) ? t_len :
      in_body ? t_body[`BODY_BITS-1 -: 8] :
      `CKSUM_GOOD - t_sum;
   wire need_esc = esc_on && idx != `IDX_DELIM && needs_escape(plain);
   wire slot = busy && (!out_valid || out_ready);
   wire adv = !need_esc || t_esc2;
   wire [7:0] out_b = !adv ? `ESC_BYTE :
      need_esc ? plain ^ `ESC_XOR : plain;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         busy <= 1'b0;
         idx <= '0;
         t_len <= '0;
         t_sum <= '0;
         t_body <= '0;
         t_esc2 <= 1'b0;
         out_data <= '0;
         out_valid <= 1'b0;
      end
      else
      begin
         if (!busy && start)
         begin
            busy <= 1'b1;
            idx <= `IDX_DELIM;
            t_len <= s_len;
            t_body <= s_body;
            t_sum <= '0;
            t_esc2 <= 1'b0;
         end
         else if (slot && !adv)
            t_esc2 <= 1'b1;
         else if (slot)
         begin
            t_esc2 <= 1'b0;
            idx <= idx + 4'h1;
            if (in_body)
            begin
               t_sum <= t_sum + plain;
               t_body <= {t_body[`BODY_BITS-9:0], 8'h00};
            end
            if (idx == last)
               busy <= 1'b0;
         end
         if (slot)
            out_data <= out_b;
         if (slot)
            out_valid <= 1'b1;
         else if (out_ready)
            out_valid <= 1'b0;
      end
   end
endmodule // frame_encoder

module frame_decoder
   import api_frame_pkg::*;
#(
   parameter logic [15:0] TAIL_FROM = `BODY_PARAM
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Byte stream in
   input wire logic esc_on,
   input wire logic in_fire,
   input wire logic [7:0] in_data,
   // Frame result, fields held until the next frame fills them; tail cleared at the next length low byte
   output logic done,
   output logic ok,
   output logic [15:0] len,
   output logic [7:0] f_type,
   output logic [7:0] f_id,
   output logic [15:0] f_cmd,
   output logic [7:0] f_b4,
   output logic [31:0] tail
);
   rx_state_t st;
   logic esc_pend;
   logic [15:0] cnt;
   logic [7:0] sum;
   // In escaped mode a raw delimiter can only open a frame
   wire resync = esc_on && in_data == `START_DELIM;
   wire esc_mark = esc_on && in_data == `ESC_BYTE && !esc_pend &&
      st != RX_HUNT;
   wire open_frame = resync || (st == RX_HUNT && in_data == `START_DELIM);
   wire [7:0] b = esc_pend ? in_data ^ `ESC_XOR : in_data;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st <= RX_HUNT;
         esc_pend <= 1'b0;
         cnt <= '0;
         sum <= '0;
         done <= 1'b0;
         ok <= 1'b0;
         len <= '0;
         f_type <= '0;
         f_id <= '0;
         f_cmd <= '0;
         f_b4 <= '0;
         tail <= '0;
      end
      else
      begin
         done <= 1'b0;
         if (in_fire && open_frame)
         begin
            st <= RX_LEN_HI;
            esc_pend <= 1'b0;
         end
         else if (in_fire && esc_mark)
            esc_pend <= 1'b1;
         else if (in_fire && st != RX_HUNT)
         begin
            esc_pend <= 1'b0;
            case (st)
               RX_LEN_HI:
               begin
                  len[15:8] <= b;
                  st <= RX_LEN_LO;
               end
               RX_LEN_LO:
               begin
                  len[7:0] <= b;
                  cnt <= '0;
                  sum <= '0;
                  tail <= '0;
                  st <= ({len[15:8], b} == '0) ? RX_HUNT : RX_BODY;
               end
               RX_BODY:
               begin
                  sum <= sum + b;
                  cnt <= cnt + 16'h0001;
                  if (cnt == `BODY_TYPE)
                     f_type <= b;
                  if (cnt == `BODY_ID)
                     f_id <= b;
                  if (cnt == `BODY_CMD_HI)
                     f_cmd[15:8] <= b;
                  if (cnt == `BODY_CMD_LO)
                     f_cmd[7:0] <= b;
                  if (cnt == `BODY_PARAM)
                     f_b4 <= b;
                  if (cnt >= TAIL_FROM)
                     tail <= {tail[23:0], b};
                  if (cnt + 16'h0001 == len)
                     st <= RX_CHK;
               end
               default:
               begin
                  done <= 1'b1;
                  ok <= sum + b == `CKSUM_GOOD;
                  st <= RX_HUNT;
               end
            endcase
         end
      end
   end
endmodule // frame_decoder

module api_frame_device
   import api_frame_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Serial link
   api_link_if.device link,
   // Events from the radio side
   input wire logic ev_valid,
   input ev_kind_t ev_kind,
   input wire logic [7:0] ev_id,
   input wire logic [7:0] ev_status,
   input wire logic ev_delivered,
   output logic ev_ready,
   // Settings in force
   output logic rx_frame_format_select,
   output logic [1:0] api_escape_mode_select,
   // Status pulses and the code of the last command run
   output logic cmd_done,
   output logic [15:0] cmd_code,
   output logic frame_bad
);
   logic dec_done, dec_ok;
   logic [15:0] dec_len, dec_cmd;
   logic [7:0] dec_type, dec_id;
   logic [31:0] dec_tail;
   logic pend, p_hasval;
   logic [7:0] p_id, p_stat;
   logic [15:0] p_cmd;
   logic [31:0] p_val;
   logic enc_busy, enc_valid, fifo_in_ready, fifo_valid;
   logic [7:0] enc_data, fifo_data;

   wire esc_on = api_escape_mode_select == `ESC_MODE_ESCAPED;
   wire has_param = dec_len > `BODY_PARAM;
   wire exec = dec_done && dec_ok && dec_type == `TYPE_LOCAL_REQ &&
      dec_len >= `BODY_PARAM;
   wire is_fmt = dec_cmd == `CMD_RX_FMT;
   wire is_esc = dec_cmd == `CMD_ESC_MODE;
   wire esc_ok = dec_tail[31:2] == '0 &&
      (dec_tail[1:0] == `ESC_MODE_PLAIN || dec_tail[1:0] == `ESC_MODE_ESCAPED);
   wire param_ok = is_fmt ? dec_tail[31:1] == '0 : esc_ok;
   wire [7:0] status = !(is_fmt || is_esc) ? `ST_BAD_CMD :
      (has_param && !param_ok) ? `ST_BAD_PARAM : `ST_OK;
   wire do_write = exec && has_param && status == `ST_OK;
   wire [31:0] cur_val = is_fmt ? {31'h0, rx_frame_format_select} :
      {30'h0, api_escape_mode_select};
   wire want_rsp = exec && dec_id != `FID_NONE;

   wire ev_fire = ev_valid && ev_ready;
   wire ev_emit = ev_fire &&
      !(ev_kind == EV_TX_STATUS && ev_id == `FID_NONE) &&
      !(ev_kind == EV_REMOTE_RSP && !ev_delivered);
   wire [7:0] ev_type = (ev_kind == EV_TX_STATUS) ? `TYPE_TX_STATUS :
      (ev_kind == EV_REMOTE_RSP) ? `TYPE_REMOTE_RSP :
      rx_frame_format_select ? `TYPE_RX_EXPLICIT : `TYPE_RX_PLAIN;
   wire start_loc = pend && !enc_busy && !ev_fire;
   wire next_pend = (pend && !start_loc) || want_rsp;
   wire [`BODY_BITS-1:0] loc_body = {`TYPE_LOCAL_RSP, p_id, p_cmd, p_stat,
      p_val};
   wire [`BODY_BITS-1:0] ev_body = {ev_type, ev_id, ev_status, 48'h0};
   wire [7:0] s_len = !start_loc ? `EV_LEN :
      p_hasval ? `RSP_LEN_QUERY : `RSP_LEN_SET;
   wire fifo_out_ready = !link.d2h_valid || link.d2h_ready;

   frame_decoder #(.TAIL_FROM(`BODY_PARAM)) u_dec (
      .clk(clk), .resetn(resetn), .esc_on(esc_on),
      .in_fire(link.h2d_valid && link.h2d_ready), .in_data(link.h2d_data),
      .done(dec_done), .ok(dec_ok), .len(dec_len), .f_type(dec_type),
      .f_id(dec_id), .f_cmd(dec_cmd), .f_b4(), .tail(dec_tail)
   );

   frame_encoder u_enc (
      .clk(clk), .resetn(resetn), .esc_on(esc_on),
      .start(ev_emit || start_loc), .s_len(s_len),
      .s_body(start_loc ? loc_body : ev_body), .busy(enc_busy),
      .out_data(enc_data), .out_valid(enc_valid), .out_ready(fifo_in_ready)
   );

   byte_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
      .clk(clk), .resetn(resetn),
      .in_data(enc_data), .in_valid(enc_valid), .in_ready(fifo_in_ready),
      .out_data(fifo_data), .out_valid(fifo_valid),
      .out_ready(fifo_out_ready)
   );

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_frame_format_select <= `RX_FMT_RST;
         api_escape_mode_select <= `ESC_MODE_PLAIN;
      end
      else if (do_write && is_fmt)
         rx_frame_format_select <= dec_tail[0];
      else if (do_write)
         api_escape_mode_select <= dec_tail[1:0];
   end

   // One response held; input stalls rather than lose a second one
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pend <= 1'b0;
         p_hasval <= 1'b0;
         p_id <= '0;
         p_cmd <= '0;
         p_stat <= '0;
         p_val <= '0;
         link.h2d_ready <= 1'b0;
         ev_ready <= 1'b0;
      end
      else
      begin
         pend <= next_pend;
         if (want_rsp)
         begin
            p_id <= dec_id;
            p_cmd <= dec_cmd;
            p_stat <= status;
            p_hasval <= !has_param && status == `ST_OK;
            p_val <= cur_val;
         end
         link.h2d_ready <= !next_pend;
         ev_ready <= !enc_busy && !(ev_emit || start_loc) && !next_pend;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         link.d2h_valid <= 1'b0;
         link.d2h_data <= '0;
         cmd_done <= 1'b0;
         cmd_code <= '0;
         frame_bad <= 1'b0;
      end
      else
      begin
         if (fifo_out_ready)
         begin
            link.d2h_valid <= fifo_valid;
            link.d2h_data <= fifo_data;
         end
         cmd_done <= exec;
         if (exec)
            cmd_code <= dec_cmd;
         frame_bad <= dec_done && !dec_ok;
      end
   end
endmodule // api_frame_device

// file: api_frame_host.sv
// Host end: sends local command requests and sorts incoming frames
`timescale 1ns/1ps
`include "api_frame_map.svh"
module api_frame_host
   import api_frame_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Serial link
   api_link_if.host link,
   // Framing mode, must match the device
   input wire logic [1:0] api_escape_mode_select,
   // Command requests
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_id,
   input wire logic [15:0] cmd_code,
   input wire logic cmd_has_param,
   input wire logic [31:0] cmd_param,
   output logic cmd_ready,
   // Command responses
   output logic rsp_valid,
   output logic [7:0] rsp_id,
   output logic [15:0] rsp_code,
   output logic [7:0] rsp_status,
   output logic [31:0] rsp_value,
   // Other frames of interest
   output logic ev_valid,
   output logic [7:0] ev_type,
   output logic [7:0] ev_id,
   output logic frame_bad
);
   logic enc_busy;
   logic dec_done, dec_ok;
   logic [15:0] dec_cmd;
   logic [7:0] dec_type, dec_id, dec_b4;
   logic [31:0] dec_tail;

   wire esc_on = api_escape_mode_select == `ESC_MODE_ESCAPED;
   wire cmd_fire = cmd_valid && cmd_ready;
   wire good = dec_done && dec_ok;
   wire is_rsp = good && dec_type == `TYPE_LOCAL_RSP;
   // Unlisted types fall through and are dropped
   wire is_event = good && (dec_type == `TYPE_TX_STATUS ||
      dec_type == `TYPE_RX_PLAIN || dec_type == `TYPE_RX_EXPLICIT ||
      dec_type == `TYPE_REMOTE_RSP);

   frame_encoder u_enc (
      .clk(clk), .resetn(resetn), .esc_on(esc_on), .start(cmd_fire),
      .s_len(cmd_has_param ? `REQ_LEN_SET : `REQ_LEN_QUERY),
      .s_body({`TYPE_LOCAL_REQ, cmd_id, cmd_code, cmd_param, 8'h00}),
      .busy(enc_busy), .out_data(link.h2d_data),
      .out_valid(link.h2d_valid), .out_ready(link.h2d_ready)
   );

   frame_decoder #(.TAIL_FROM(`BODY_VALUE)) u_dec (
      .clk(clk), .resetn(resetn), .esc_on(esc_on),
      .in_fire(link.d2h_valid && link.d2h_ready), .in_data(link.d2h_data),
      .done(dec_done), .ok(dec_ok), .len(), .f_type(dec_type),
      .f_id(dec_id), .f_cmd(dec_cmd), .f_b4(dec_b4), .tail(dec_tail)
   );

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cmd_ready <= 1'b0;
         link.d2h_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_id <= '0;
         rsp_code <= '0;
         rsp_status <= '0;
         rsp_value <= '0;
         ev_valid <= 1'b0;
         ev_type <= '0;
         ev_id <= '0;
         frame_bad <= 1'b0;
      end
      else
      begin
         cmd_ready <= !enc_busy && !cmd_fire;
         link.d2h_ready <= 1'b1;
         rsp_valid <= is_rsp;
         if (is_rsp)
         begin
            rsp_id <= dec_id;
            rsp_code <= dec_cmd;
            rsp_status <= dec_b4;
            rsp_value <= dec_tail;
         end
         ev_valid <= is_event;
         if (is_event)
         begin
            ev_type <= dec_type;
            ev_id <= dec_id;
         end
         frame_bad <= dec_done && !dec_ok;
      end
   end
endmodule // api_frame_host

// file: api_frame_parser_local_command_properties.sv
// Link checker: framing, checksum and handshake properties of both streams
`timescale 1ns/1ps
module link_frame_track
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Byte stream seen
   input wire logic [7:0] data,
   input wire logic fire,
   // Frame position and running sum
   output logic [15:0] pos,
   output logic [7:0] len,
   output logic [7:0] sum,
   output logic [7:0] val,
   output logic [7:0] total,
   output logic take
);
   logic esc;
   wire is_delim = data == 8'h7e;
   wire is_esc = data == 8'h7d;
   assign val = esc ? data ^ 8'h20 : data;
   assign total = sum + val;
   assign take = fire && !is_delim && !is_esc && pos != 16'h0000;
   // Raw 0x7d only comes from escaping, so plain traffic must avoid it
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pos <= 16'h0000;
         len <= 8'h00;
         sum <= 8'h00;
         esc <= 1'b0;
      end
      else if (fire && is_delim)
      begin
         pos <= 16'h0001;
         sum <= 8'h00;
         esc <= 1'b0;
      end
      else if (fire && is_esc)
         esc <= 1'b1;
      else if (take)
      begin
         pos <= pos + 16'h0001;
         esc <= 1'b0;
         if (pos == 16'h0002)
            len <= val;
         if (pos >= 16'h0003)
            sum <= total;
      end
   end
endmodule // link_frame_track

module api_link_checker
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Link signals
   input wire logic [7:0] h2d_data,
   input wire logic h2d_valid,
   input wire logic h2d_ready,
   input wire logic [7:0] d2h_data,
   input wire logic d2h_valid,
   input wire logic d2h_ready
);
   logic [15:0] hp, dp;
   logic [7:0] hl, dl, hs, ds, hv, dv, ht, dt;
   logic htake, dtake;
   link_frame_track h_i (.clk(clk), .resetn(resetn), .data(h2d_data),
      .fire(h2d_valid && h2d_ready), .pos(hp), .len(hl), .sum(hs),
      .val(hv), .total(ht), .take(htake));
   link_frame_track d_i (.clk(clk), .resetn(resetn), .data(d2h_data),
      .fire(d2h_valid && d2h_ready), .pos(dp), .len(dl), .sum(ds),
      .val(dv), .total(dt), .take(dtake));

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   property p_h2d_hold;
      h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data);
   endproperty
   a_h2d_hold: assert property (p_h2d_hold) else $error("host byte changed before taken");
   property p_d2h_hold;
      d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data);
   endproperty
   a_d2h_hold: assert property (p_d2h_hold) else $error("device byte changed before taken");
   property p_h2d_len_hi;
      htake && hp == 16'h0001 |-> hv == 8'h00;
   endproperty
   a_h2d_len_hi: assert property (p_h2d_len_hi) else $error("host length high byte wrong");
   property p_d2h_len_hi;
      dtake && dp == 16'h0001 |-> dv == 8'h00;
   endproperty
   a_d2h_len_hi: assert property (p_d2h_len_hi) else $error("device length high byte wrong");
   property p_h2d_len;
      htake && hp == 16'h0002 |-> hv inside {8'h04, 8'h08};
   endproperty
   a_h2d_len: assert property (p_h2d_len) else $error("host length wrong");
   property p_d2h_len;
      dtake && dp == 16'h0002 |-> dv inside {8'h03, 8'h05, 8'h09};
   endproperty
   a_d2h_len: assert property (p_d2h_len) else $error("device length wrong");
   property p_h2d_type;
      htake && hp == 16'h0003 |-> hv == 8'h08;
   endproperty
   a_h2d_type: assert property (p_h2d_type) else $error("host frame type wrong");
   property p_d2h_type;
      dtake && dp == 16'h0003 |->
         dv inside {8'h88, 8'h8b, 8'h90, 8'h91, 8'h97};
   endproperty
   a_d2h_type: assert property (p_d2h_type) else $error("device frame type wrong");
   property p_h2d_cksum;
      htake && hp == {8'h00, hl} + 16'h0003 |-> ht == 8'hff;
   endproperty
   a_h2d_cksum: assert property (p_h2d_cksum) else $error("host checksum wrong");
   property p_d2h_cksum;
      dtake && dp == {8'h00, dl} + 16'h0003 |-> dt == 8'hff;
   endproperty
   a_d2h_cksum: assert property (p_d2h_cksum) else $error("device checksum wrong");
   c_refused: cover property (h2d_valid && !h2d_ready);
   c_escaped: cover property (d2h_valid && d2h_ready && d2h_data == 8'h7d);
   c_fmt_one: cover property (dtake && dp == 16'h0003 && dv == 8'h91);
endmodule // api_link_checker

// file: api_frame_parser_local_command_tb_top.sv
// Testbench joining host and device ends over the serial API link
`timescale 1ns/1ps
module api_frame_parser_local_command_tb_top
   import api_frame_pkg::*;
();
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic cmd_valid = 1'b0, cmd_has_param = 1'b0;
   logic [7:0] cmd_id = 8'h00;
   logic [15:0] cmd_code = 16'h0000;
   logic [31:0] cmd_param = 32'h0;
   logic ev_valid = 1'b0, ev_delivered = 1'b0;
   ev_kind_t ev_kind = EV_TX_STATUS;
   logic [7:0] ev_id = 8'h00, ev_status = 8'h00;
   wire cmd_ready, rsp_valid, host_ev_valid, host_bad, ev_ready, fmt, fmt2;
   wire [7:0] rsp_id, rsp_status, host_ev_type, host_ev_id;
   wire [15:0] rsp_code, code2;
   wire [31:0] rsp_value;
   wire [1:0] esc_mode, esc2;
   wire bad2;
   logic bad2_seen = 1'b0, bad_seen = 1'b0;
   logic [7:0] seq2[$];
   int errors = 0, samples_checked = 0, cycles = 0;
   api_link_if link();
   api_link_if link2();

   api_frame_device api_frame_device_i (.clk(clk), .resetn(resetn),
      .link(link), .ev_valid(ev_valid), .ev_kind(ev_kind), .ev_id(ev_id),
      .ev_status(ev_status), .ev_delivered(ev_delivered),
      .ev_ready(ev_ready), .rx_frame_format_select(fmt),
      .api_escape_mode_select(esc_mode), .cmd_done(), .cmd_code(),
      .frame_bad());
   api_frame_host api_frame_host_i (.clk(clk), .resetn(resetn),
      .link(link), .api_escape_mode_select(esc_mode),
      .cmd_valid(cmd_valid), .cmd_id(cmd_id), .cmd_code(cmd_code),
      .cmd_has_param(cmd_has_param), .cmd_param(cmd_param),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_id(rsp_id),
      .rsp_code(rsp_code), .rsp_status(rsp_status),
      .rsp_value(rsp_value), .ev_valid(host_ev_valid),
      .ev_type(host_ev_type), .ev_id(host_ev_id), .frame_bad(host_bad));
   // Second device faces the bench so faulty frames can be sent
   api_frame_device api_frame_device_i2 (.clk(clk), .resetn(resetn),
      .link(link2), .ev_valid(1'b0), .ev_kind(EV_TX_STATUS),
      .ev_id(8'h00), .ev_status(8'h00), .ev_delivered(1'b0),
      .ev_ready(), .rx_frame_format_select(fmt2),
      .api_escape_mode_select(esc2), .cmd_done(), .cmd_code(code2),
      .frame_bad(bad2));
   api_link_checker api_link_checker_i (.clk(clk), .resetn(resetn),
      .h2d_data(link.h2d_data), .h2d_valid(link.h2d_valid),
      .h2d_ready(link.h2d_ready), .d2h_data(link.d2h_data),
      .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready));

   initial
   begin
      link2.h2d_data = 8'h00;
      link2.h2d_valid = 1'b0;
      link2.d2h_ready = 1'b0;
   end
   always #12.5 clk = ~clk;

   task results;
      $display("%0d compared, %0d wrong", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Ceiling is many times the expected few hundred cycles
   always @(posedge clk)
   begin
      cycles++;
      if (bad2 === 1'b1)
         bad2_seen <= 1'b1;
      if (host_bad === 1'b1)
         bad_seen <= 1'b1;
      if (cycles == 20000)
      begin
         errors++;
         results;
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wait_for(input bit which, output bit got);
      got = 1'b0;
      repeat (80)
      begin
         @(posedge clk);
         #1;
         if ((which ? host_ev_valid : rsp_valid) === 1'b1)
         begin
            got = 1'b1;
            break;
         end
      end
   endtask

   task run_cmd(input logic [7:0] id, input logic [15:0] code,
      input logic has_p, input logic [31:0] p, input logic [7:0] st,
      input logic [31:0] value);
      bit got;
      int i;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_id <= id;
      cmd_code <= code;
      cmd_has_param <= has_p;
      cmd_param <= p;
      i = 0;
      do begin @(posedge clk); i++; end while (cmd_ready !== 1'b1 && i < 100);
      cmd_valid <= 1'b0;
      wait_for(1'b0, got);
      check(got, id != 8'h00);
      if (got)
      begin
         check(rsp_id, id);
         check(rsp_code, code);
         check(rsp_status, st);
         check(rsp_value, value);
      end
   endtask

   task send_ev(input ev_kind_t kind, input logic [7:0] id,
      input logic dlv, input logic [7:0] exp_type);
      bit got;
      int i;
      @(posedge clk);
      ev_valid <= 1'b1;
      ev_kind <= kind;
      ev_id <= id;
      ev_delivered <= dlv;
      i = 0;
      do begin @(posedge clk); i++; end while (ev_ready !== 1'b1 && i < 100);
      ev_valid <= 1'b0;
      wait_for(1'b1, got);
      check(got, exp_type != 8'h00);
      if (got)
      begin
         check(host_ev_type, exp_type);
         check(host_ev_id, id);
      end
   endtask

   // Called at an edge; holds the byte until the device takes it
   task send2;
      int i;
      @(posedge clk);
      foreach (seq2[k])
      begin
         link2.h2d_data <= seq2[k];
         link2.h2d_valid <= 1'b1;
         i = 0;
         do begin @(posedge clk); i++; end
            while (link2.h2d_ready !== 1'b1 && i < 100);
      end
      link2.h2d_valid <= 1'b0;
      link2.h2d_data <= ~seq2[seq2.size() - 1];
      repeat (3) @(posedge clk);
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      link2.d2h_ready <= 1'b1;
      repeat (2) @(posedge clk);
      check(fmt, 1'b0);
      check(esc_mode, 2'h1);
      run_cmd(8'h17, 16'h414f, 1'b0, 32'h0, 8'h00, 32'h0);
      run_cmd(8'h17, 16'h5450, 1'b0, 32'h0, 8'h02, 32'h0);
      $display("test query done");
      run_cmd(8'h21, 16'h414f, 1'b1, 32'h1, 8'h00, 32'h0);
      check(fmt, 1'b1);
      run_cmd(8'h22, 16'h414f, 1'b0, 32'h0, 8'h00, 32'h1);
      $display("test set done");
      send_ev(EV_RX_DATA, 8'h31, 1'b0, 8'h91);
      send_ev(EV_TX_STATUS, 8'h55, 1'b0, 8'h8b);
      send_ev(EV_TX_STATUS, 8'h00, 1'b0, 8'h00);
      send_ev(EV_REMOTE_RSP, 8'h66, 1'b1, 8'h97);
      send_ev(EV_REMOTE_RSP, 8'h67, 1'b0, 8'h00);
      run_cmd(8'h00, 16'h414f, 1'b1, 32'h0, 8'h00, 32'h0);
      check(fmt, 1'b0);
      send_ev(EV_RX_DATA, 8'h32, 1'b0, 8'h90);
      $display("test events done");
      run_cmd(8'h44, 16'h4150, 1'b1, 32'h2, 8'h00, 32'h0);
      check(esc_mode, 2'h2);
      run_cmd(8'h7e, 16'h4150, 1'b0, 32'h0, 8'h00, 32'h2);
      run_cmd(8'h7d, 16'h4150, 1'b1, 32'h0, 8'h03, 32'h0);
      run_cmd(8'h13, 16'h4150, 1'b1, 32'h1, 8'h00, 32'h0);
      check(esc_mode, 2'h1);
      $display("test escape done");
      seq2 = '{8'h00, 8'h05, 8'h08, 8'h00, 8'h41, 8'h4f, 8'h01, 8'h66};
      send2();
      check(fmt2, 1'b0);
      seq2 = '{8'h7e, 8'h00, 8'h05, 8'h08, 8'h00, 8'h41, 8'h4f, 8'h01, 8'h67};
      send2();
      check(bad2_seen, 1'b1);
      check(fmt2, 1'b0);
      check(code2, 16'h0000);
      seq2[8] = 8'h66;
      send2();
      check(fmt2, 1'b1);
      check(esc2, 2'h1);
      check(code2, 16'h414f);
      check(bad_seen, 1'b0);
      $display("test faults done");
      results;
   end
endmodule // api_frame_parser_local_command_tb_top
